// ---- rtl/ltc_pkg.sv ----
// package for the single-wire bus transceiver mode controller
// assumes a 40 MHz timebase clock shared by every file of the block
package ltc_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CLK_NS        = 25;
  // times as printed, in their own units
  localparam int unsigned DOM_TIMEOUT_US   = 6000;  // dominant_timeout, 6 ms
  localparam int unsigned TXD_RELEASE_NS   = 10000; // 10 us high to re-arm
  localparam int unsigned RESET_HOLD_US    = 4000;  // 4 ms host reset
  localparam int unsigned IGN_DEBOUNCE_US  = 160;   // ignition filter
  localparam int unsigned BUS_WAKE_US      = 150;   // bus wake dominant time
  // cycle counts: least times round up
  localparam int unsigned DOM_TIMEOUT_CYC  = DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TXD_RELEASE_CYC  = (TXD_RELEASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESET_HOLD_CYC   = RESET_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IGN_DEBOUNCE_CYC = IGN_DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BUS_WAKE_CYC     = BUS_WAKE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W            = 20;

  typedef enum logic [2:0] {
    LTC_UNPOWERED = 3'b000,
    LTC_FAILSAFE  = 3'b001,
    LTC_NORMAL    = 3'b010,
    LTC_SILENT    = 3'b011,
    LTC_SLEEP     = 3'b100
  } ltc_mode_e;

  typedef enum logic [1:0] {
    LTC_WK_NONE  = 2'b00,
    LTC_WK_BUS   = 2'b01,
    LTC_WK_LOCAL = 2'b10
  } ltc_wake_e;

  // analog status levels, already digital comparators
  typedef struct packed {
    logic supply_ok;    // battery_supply above supply_undervoltage_threshold
    logic supply_on;    // battery_supply above 0 V
    logic reg_ok;       // regulator output above its threshold
    logic bus_recessive;
  } ltc_status_s;
endpackage : ltc_pkg

// ---- rtl/ltc_fifo.sv ----
// small flop FIFO with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
module ltc_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];

  // pointer wrap assumes a power-of-two depth
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset, the occupancy count guards it
  always_ff @(posedge i_clock) begin
    if (push) mem_q[wr_q] <= i_in_data;
  end
endmodule : ltc_fifo

// ---- rtl/ltc_mode_ctrl.sv ----
// mode controller and bus data paths of the single-wire transceiver
// assumes pins and comparator outputs are asynchronous to i_clock
`timescale 1ns/100ps
// Functional notes
// - battery under-voltage blocks every bus transmission
// - first supply application enters fail-safe and enables the regulator
// - reset_out_n low whenever the regulator output is under-voltage
// - normal mode: transmit low drives dominant, high or floating stays recessive
// - fail-safe: transmit pin becomes output, low after local or ignition wake
// - transmit low beyond 6 ms forces the driver recessive
// - after time-out, driver stays off until transmit high over 10 us
// - in normal mode receive output follows bus: high recessive, low dominant
// - receive output switched off when battery supply is absent
// - enable high gives normal mode, both paths on, regulator on
// - enable falling with transmit high enters silent mode
// - enable falling with transmit low enters sleep, regulator off
// - local wake input wakes from sleep or silent
// - watchdog-disable strap high switches watchdog off, low runs it in normal and fail-safe
// - paths support 20 kBaud
// - bus wake pulse in sleep or silent enters fail-safe, receive low
// - fail-safe until enable high, then normal; reset low forces fail-safe except in sleep
// - power-up fail-safe holds reset_out_n low for 4 ms
// - ignition rising edge, debounced 160 us, is a wake event
module ltc_mode_ctrl
  import ltc_pkg::*;
#(
  parameter int unsigned DOM_CYC   = DOM_TIMEOUT_CYC,
  parameter int unsigned RES_CYC   = RESET_HOLD_CYC,
  parameter int unsigned BWAKE_CYC = BUS_WAKE_CYC,
  parameter int unsigned IGN_CYC   = IGN_DEBOUNCE_CYC,
  parameter int unsigned FIFO_DEPTH = 4
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire ltc_status_s i_status,
  input  wire logic        i_txd,
  input  wire logic        i_enable,
  input  wire logic        i_local_wake_n,
  input  wire logic        i_ignition_wake_input,
  input  wire logic        i_wdog_disable_strap,
  input  wire logic        i_factory_test_input,
  output logic             o_bus_dominant,
  output logic             o_rxd,
  output logic             o_rxd_oe,
  output logic             o_txd_out,
  output logic             o_txd_oe,
  output logic             o_reg_on,
  output logic             o_reset_out_n,
  output logic             o_inh,
  output logic             o_wdog_en,
  output logic [2:0]       o_mode
);
  // two-flop synchronisers for all asynchronous inputs
  localparam int unsigned NSYNC = 10;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  wire  [NSYNC-1:0] raw = {i_status, i_txd, i_enable, i_local_wake_n,
                           i_ignition_wake_input, i_wdog_disable_strap, i_factory_test_input};
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s1_q <= NSYNC'(10'h3e8); // idle pin levels, enable low so no false edge
      s2_q <= NSYNC'(10'h3e8);
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire supply_ok = s2_q[9];
  wire supply_on = s2_q[8];
  wire reg_ok    = s2_q[7];
  wire bus_rec   = s2_q[6];
  wire txd       = s2_q[5];
  wire en        = s2_q[4];
  wire lwake_n   = s2_q[3];
  wire ign       = s2_q[2];
  wire wd_strap  = s2_q[1];

  ltc_mode_e mode_q;
  ltc_mode_e mode_d;
  ltc_wake_e wake_q;
  logic      en_q;
  logic      lwake_q;
  logic      ign_q;
  logic      bus_q;
  logic [CNT_W-1:0] dom_q;
  logic [CNT_W-1:0] rel_q;
  logic             tout_q;
  logic [CNT_W-1:0] res_q;
  logic [CNT_W-1:0] bw_q;
  logic [CNT_W-1:0] ig_q;
  logic             ign_arm_q;

  // edge and event decode
  wire en_fall   = en_q && !en;
  wire lwake_ev  = lwake_q && !lwake_n;           // falling edge on local wake
  wire ign_rise  = !ign_q && ign;
  wire ign_ev    = ign_arm_q && ign && (ig_q == CNT_W'(IGN_CYC));
  wire bus_ev    = !bus_q && bus_rec && (bw_q >= CNT_W'(BWAKE_CYC));
  wire low_power = (mode_q == LTC_SLEEP) || (mode_q == LTC_SILENT);
  wire local_ev  = low_power && (lwake_ev || ign_ev);
  wire res_busy  = (res_q != '0);
  wire reset_low = res_busy || !reg_ok;

  // mode transitions
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      LTC_UNPOWERED: if (supply_ok) mode_d = LTC_FAILSAFE;
      LTC_FAILSAFE:  if (en && !reset_low) mode_d = LTC_NORMAL;
      LTC_NORMAL: begin
        if (reset_low) mode_d = LTC_FAILSAFE;
        else if (en_fall) mode_d = txd ? LTC_SILENT : LTC_SLEEP;
      end
      LTC_SILENT, LTC_SLEEP: begin
        if (local_ev || bus_ev || en || !supply_ok) mode_d = LTC_FAILSAFE;
        else if (mode_q == LTC_SILENT && reset_low) mode_d = LTC_FAILSAFE;
      end
      default: mode_d = LTC_FAILSAFE;
    endcase
    if (!supply_on) mode_d = LTC_UNPOWERED;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_q    <= LTC_UNPOWERED;
      en_q      <= 1'b0;
      lwake_q   <= 1'b1;
      ign_q     <= 1'b0;
      bus_q     <= 1'b1;
    end else begin
      mode_q  <= mode_d;
      en_q    <= en;
      lwake_q <= lwake_n;
      ign_q   <= ign;
      bus_q   <= bus_rec;
    end
  end

  // last wake source, kept until the next wake, cleared while unpowered
  always_ff @(posedge i_clock) begin
    if (i_rst) wake_q <= LTC_WK_NONE;
    else if (local_ev) wake_q <= LTC_WK_LOCAL;
    else if (low_power && bus_ev) wake_q <= LTC_WK_BUS;
    else if (mode_q == LTC_UNPOWERED) wake_q <= LTC_WK_NONE;
  end

  // ignition debounce: level must stay high after the rising edge
  always_ff @(posedge i_clock) begin
    if (i_rst || !ign) begin
      ig_q      <= '0;
      ign_arm_q <= 1'b0;
    end else if (ign_rise) begin
      ig_q      <= '0;
      ign_arm_q <= 1'b1;
    end else if (ign_arm_q) begin
      if (ig_q == CNT_W'(IGN_CYC)) ign_arm_q <= 1'b0; // one event per edge
      else ig_q <= ig_q + 1'b1;
    end
  end

  // bus dominant length for remote wake, saturating
  always_ff @(posedge i_clock) begin
    if (i_rst || (bus_rec && bus_q)) bw_q <= '0;
    else if (!bus_rec && bw_q != CNT_W'(BWAKE_CYC)) bw_q <= bw_q + 1'b1;
  end

  // power-up reset hold, restarted on every entry from unpowered
  always_ff @(posedge i_clock) begin
    if (i_rst) res_q <= '0;
    else if (mode_q == LTC_UNPOWERED && mode_d == LTC_FAILSAFE) res_q <= CNT_W'(RES_CYC);
    else if (res_busy) res_q <= res_q - 1'b1;
  end

  // dominant time-out and release timer on the transmit input
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dom_q  <= '0;
      rel_q  <= '0;
      tout_q <= 1'b0;
    end else if (!txd) begin
      rel_q <= '0;
      if (dom_q == CNT_W'(DOM_CYC)) tout_q <= 1'b1;
      else dom_q <= dom_q + 1'b1;
    end else begin
      dom_q <= '0;
      if (rel_q == CNT_W'(TXD_RELEASE_CYC)) tout_q <= 1'b0;
      else rel_q <= rel_q + 1'b1;
    end
  end

  // bus driver path goes through the small FIFO; sampling at 40 MHz is
  // far beyond 20 kBaud, so a few cycles of latency cost nothing
  wire tx_dom_d = (mode_q == LTC_NORMAL) && !txd && !tout_q && supply_ok;
  wire tx_valid;
  wire tx_ready;
  wire tx_out;
  ltc_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) ltc_fifo_i (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (1'b1),
    .i_in_data   (tx_dom_d),
    .o_in_ready  (tx_ready),
    .o_out_valid (tx_valid),
    .i_out_ready (1'b1),
    .o_out_data  (tx_out)
  );

  // receive output per mode
  wire rx_d = (mode_q == LTC_NORMAL)   ? bus_rec :
              (mode_q == LTC_FAILSAFE) ? (wake_q != LTC_WK_BUS) :
              (mode_q == LTC_SILENT);
  wire outs_on = (mode_q == LTC_NORMAL) || (mode_q == LTC_FAILSAFE);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_bus_dominant <= 1'b0;
      o_rxd          <= 1'b1;
      o_rxd_oe       <= 1'b0;
      o_txd_out      <= 1'b1;
      o_txd_oe       <= 1'b0;
      o_reg_on       <= 1'b0;
      o_reset_out_n  <= 1'b0;
      o_inh          <= 1'b0;
      o_wdog_en      <= 1'b0;
      o_mode         <= 3'h0;
    end else begin
      o_bus_dominant <= tx_valid && tx_ready && tx_out && supply_ok;
      o_rxd          <= rx_d;
      o_rxd_oe       <= supply_on && mode_q != LTC_UNPOWERED;
      o_txd_out      <= (wake_q != LTC_WK_LOCAL);
      o_txd_oe       <= (mode_q == LTC_FAILSAFE);
      o_reg_on       <= (mode_q != LTC_SLEEP) && (mode_q != LTC_UNPOWERED);
      o_reset_out_n  <= !reset_low && mode_q != LTC_SLEEP;
      o_inh          <= outs_on && !reset_low;
      o_wdog_en      <= outs_on && !wd_strap;
      o_mode         <= mode_q;
    end
  end

  // assertions
  dom_timeout_a: assert property (@(posedge i_clock) disable iff (i_rst)
    tout_q |-> ##2 !o_bus_dominant [*3]) else $error("driver active after time-out");
  uv_block_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !supply_ok |=> !o_bus_dominant) else $error("transmit during under-voltage");
  reset_low_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !reg_ok |=> !o_reset_out_n) else $error("reset not low on regulator fault");
  sleep_entry_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == LTC_NORMAL && en_fall && !txd && !reset_low && supply_on) |=> mode_q == LTC_SLEEP)
    else $error("sleep not entered");
  silent_entry_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == LTC_NORMAL && en_fall && txd && !reset_low && supply_on) |=> mode_q == LTC_SILENT)
    else $error("silent not entered");
  reg_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == LTC_SLEEP |=> !o_reg_on) else $error("regulator on in sleep");
  rx_follow_a: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == LTC_NORMAL |=> o_rxd == $past(bus_rec)) else $error("receive not following bus");
  rx_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !supply_on |=> !o_rxd_oe) else $error("receive driven while unpowered");
  wdog_strap_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wd_strap |=> !o_wdog_en) else $error("watchdog on with strap high");
  fs_exit_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == LTC_FAILSAFE && en && !reset_low && supply_on) |=> mode_q == LTC_NORMAL)
    else $error("fail-safe exit missed");
  // a held reset must pin fail-safe, else the mode flips every cycle
  fs_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == LTC_FAILSAFE && reset_low && supply_on) |=> mode_q == LTC_FAILSAFE)
    else $error("fail-safe left during reset");
  normal_fault_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == LTC_NORMAL && reset_low && supply_on) |=> mode_q == LTC_FAILSAFE)
    else $error("normal kept during reset");
  reset_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    res_busy |=> !o_reset_out_n)
    else $error("host reset released early");
  power_up_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == LTC_UNPOWERED && supply_ok && supply_on) |=> (mode_q == LTC_FAILSAFE) ##1 o_reg_on)
    else $error("power-up entry missed");
  fs_txd_oe_a: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == LTC_FAILSAFE |=> o_txd_oe)
    else $error("transmit pin not output in fail-safe");
  local_wake_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (local_ev && supply_on) |=> (mode_q == LTC_FAILSAFE) ##1 !o_txd_out)
    else $error("local wake not taken");
  ign_wake_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (low_power && ign_ev && supply_on) |=> mode_q == LTC_FAILSAFE)
    else $error("ignition wake not taken");
  bus_wake_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (low_power && bus_ev && !local_ev && supply_on) |=> (mode_q == LTC_FAILSAFE) ##1 !o_rxd)
    else $error("bus wake not taken");
  // two cycles: one through the fifo, one into the output flop
  silent_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == LTC_SILENT |-> ##2 !o_bus_dominant)
    else $error("driver active in silent");
  sleep_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == LTC_SLEEP |-> ##2 !o_bus_dominant)
    else $error("driver active in sleep");
  normal_tx_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == LTC_NORMAL && !txd && !tout_q && supply_ok) ##1 supply_ok |-> ##1 o_bus_dominant)
    else $error("dominant not driven");
  normal_rec_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (mode_q == LTC_NORMAL && txd) |-> ##2 !o_bus_dominant)
    else $error("dominant with transmit high");
  dom_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (tout_q && !txd) |=> tout_q)
    else $error("time-out cleared while transmit low");
endmodule : ltc_mode_ctrl

// ---- bench/ltc_host_model.sv ----
// host controller model on the logic side of the transceiver
// assumes the bench drives it through its tasks, one clock domain
`timescale 1ns/100ps
module ltc_host_model #(
  parameter int unsigned BIT_CYC = 2000  // 20 kBaud at 40 MHz
) (
  input  wire logic i_clock,
  input  wire logic i_rxd,
  output logic      o_txd,
  output logic      o_enable,
  output logic      o_factory_test
);
  // idle: a released transmit pin reads high through its pull-up
  initial begin
    o_txd          = 1'b1;
    o_enable       = 1'b0;
    o_factory_test = 1'b0;
  end

  // levels change just after the edge and stand until the next call
  task automatic set_pins(input logic txd, input logic en);
    @(posedge i_clock);
    o_txd    <= txd;
    o_enable <= en;
  endtask : set_pins

  // one bit at bus rate, receive level sampled mid-bit
  task automatic tx_bit(input logic b, output logic seen);
    set_pins(b, 1'b1);
    repeat (BIT_CYC / 2) @(posedge i_clock);
    seen = i_rxd;
    repeat (BIT_CYC / 2) @(posedge i_clock);
  endtask : tx_bit
endmodule : ltc_host_model

// ---- bench/ltc_mode_ctrl_bench.sv ----
// self-checking bench for the transceiver mode controller
// assumes short time parameters; bus wire modelled from the driver
`timescale 1ns/100ps
module ltc_mode_ctrl_bench;
  import ltc_pkg::*;
  localparam int unsigned DOM_T = 3000;  // above one 20 kBaud bit
  localparam int unsigned RES_T = 30;
  localparam int unsigned BWK_T = 10;
  localparam int unsigned IGN_T = 10;
  logic        i_clock, i_rst, sup_ok, sup_on, reg_ok, ext_dom, wake_n, ign, strap;
  logic        txd, en, ftest, dom, rxd, rxd_oe, txd_out, txd_oe, reg_on, res_n, inh, wdog_en, seen;
  logic [2:0]  mode;
  ltc_status_s status;
  int          num_errors;
  int          checks_done;

  // bus dominant when our driver or another node pulls it
  assign status = {sup_ok, sup_on, reg_ok, ~(dom | ext_dom)};

  ltc_mode_ctrl #(.DOM_CYC(DOM_T), .RES_CYC(RES_T), .BWAKE_CYC(BWK_T), .IGN_CYC(IGN_T)) ltc_mode_ctrl_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_status(status), .i_txd(txd), .i_enable(en),
    .i_local_wake_n(wake_n), .i_ignition_wake_input(ign), .i_wdog_disable_strap(strap),
    .i_factory_test_input(ftest), .o_bus_dominant(dom), .o_rxd(rxd), .o_rxd_oe(rxd_oe),
    .o_txd_out(txd_out), .o_txd_oe(txd_oe), .o_reg_on(reg_on), .o_reset_out_n(res_n),
    .o_inh(inh), .o_wdog_en(wdog_en), .o_mode(mode));
  ltc_host_model ltc_host_model_i (.i_clock(i_clock), .i_rxd(rxd), .o_txd(txd), .o_enable(en),
    .o_factory_test(ftest));

  // compare and count
  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  // sample after the edge so registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : settle

  // bounded wait for a mode
  task automatic wait_mode(input logic [2:0] m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      settle(1);
      n++;
    end
    chk(mode === m, 1'b1, "mode not reached");
  endtask : wait_mode

  task automatic t_powerup;
    wait_mode(LTC_FAILSAFE, 10);
    chk(reg_on, 1'b1, "regulator off at power-up");
    chk(res_n, 1'b0, "no host reset");
    ltc_host_model_i.set_pins(1'b1, 1'b1);
    settle(RES_T - 12);
    chk(res_n, 1'b0, "host reset too short");
    chk(mode === LTC_FAILSAFE, 1'b1, "mode change during reset hold");
    wait_mode(LTC_NORMAL, 30);
    chk(res_n & reg_on, 1'b1, "normal mode outputs");
    chk(wdog_en, 1'b1, "watchdog off with strap low");
    strap <= 1'b1;
    settle(8);
    chk(wdog_en, 1'b0, "watchdog on with strap high");
    strap <= 1'b0;
  endtask : t_powerup

  task automatic t_transmit;
    for (int i = 0; i < 4; i++) begin
      ltc_host_model_i.tx_bit(i[0], seen);
      chk(seen, i[0], "loopback bit");
    end
    ext_dom <= 1'b1;
    settle(8);
    chk(rxd, 1'b0, "receive not low on dominant bus");
    ext_dom <= 1'b0;
    settle(8);
    chk(rxd, 1'b1, "receive not high on recessive bus");
  endtask : t_transmit

  task automatic t_timeout;
    ltc_host_model_i.set_pins(1'b0, 1'b1);
    settle(DOM_T / 2);
    chk(dom, 1'b1, "driver cut early");
    settle(DOM_T / 2 + 20);
    chk(dom, 1'b0, "driver not cut");
    ltc_host_model_i.set_pins(1'b1, 1'b1);
    settle(TXD_RELEASE_CYC / 2);
    ltc_host_model_i.set_pins(1'b0, 1'b1);
    settle(10);
    chk(dom, 1'b0, "re-armed by short release");
    ltc_host_model_i.set_pins(1'b1, 1'b1);
    settle(TXD_RELEASE_CYC + 20);
    ltc_host_model_i.set_pins(1'b0, 1'b1);
    settle(10);
    chk(dom, 1'b1, "not re-armed");
    ltc_host_model_i.set_pins(1'b1, 1'b1);
    settle(10);
  endtask : t_timeout

  // battery and regulator faults in normal mode
  task automatic t_faults;
    sup_ok <= 1'b0;
    ltc_host_model_i.set_pins(1'b0, 1'b1);
    settle(10);
    chk(dom, 1'b0, "sent under low battery");
    ltc_host_model_i.set_pins(1'b1, 1'b1);
    sup_ok <= 1'b1;
    wait_mode(LTC_NORMAL, RES_T + 60);
    reg_ok <= 1'b0;
    settle(8);
    chk(res_n, 1'b0, "reset not low on regulator fail");
    chk(inh, 1'b0, "inhibit on during regulator fail");
    wait_mode(LTC_FAILSAFE, 10);
    settle(4);
    chk(mode === LTC_FAILSAFE, 1'b1, "fail-safe left during reset");
    reg_ok <= 1'b1;
    wait_mode(LTC_NORMAL, RES_T + 60);
  endtask : t_faults

  task automatic t_silent;
    ltc_host_model_i.set_pins(1'b1, 1'b0);
    wait_mode(LTC_SILENT, 15);
    chk(reg_on, 1'b1, "regulator off in silent");
    ltc_host_model_i.set_pins(1'b0, 1'b0);
    settle(10);
    chk(dom, 1'b0, "sent in silent");
    ltc_host_model_i.set_pins(1'b1, 1'b0);
    wake_n <= 1'b0;
    wait_mode(LTC_FAILSAFE, 15);
    wake_n <= 1'b1;
    settle(4);
    chk(txd_oe & ~txd_out, 1'b1, "local wake not signalled");
    ltc_host_model_i.set_pins(1'b1, 1'b1);
    wait_mode(LTC_NORMAL, RES_T + 60);
  endtask : t_silent

  task automatic t_sleep;
    ltc_host_model_i.set_pins(1'b0, 1'b0);
    wait_mode(LTC_SLEEP, 15);
    chk(reg_on, 1'b0, "regulator on in sleep");
    ltc_host_model_i.set_pins(1'b1, 1'b0);
    ext_dom <= 1'b1;
    settle(3);
    ext_dom <= 1'b0;
    settle(10);
    chk(mode === LTC_SLEEP, 1'b1, "short pulse woke");
    ext_dom <= 1'b1;
    settle(BWK_T + 5);
    ext_dom <= 1'b0;
    wait_mode(LTC_FAILSAFE, 15);
    chk(rxd, 1'b0, "bus wake not flagged");
    chk(txd_out, 1'b1, "bus wake shown as local");
    ltc_host_model_i.set_pins(1'b1, 1'b1);
    wait_mode(LTC_NORMAL, RES_T + 60);
    ltc_host_model_i.set_pins(1'b0, 1'b0);
    wait_mode(LTC_SLEEP, 15);
    ltc_host_model_i.set_pins(1'b1, 1'b0);
    ign <= 1'b1;
    settle(3);
    ign <= 1'b0;
    settle(15);
    chk(mode === LTC_SLEEP, 1'b1, "ignition glitch woke");
    ign <= 1'b1;
    wait_mode(LTC_FAILSAFE, IGN_T + 15);
    settle(4);
    chk(txd_out, 1'b0, "ignition wake not signalled");
    sup_on <= 1'b0;
    settle(8);
    chk(rxd_oe, 1'b0, "receive on unpowered");
  endtask : t_sleep

  task automatic end_of_test;
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // watchdog well past the expected run of about 12000 cycles
  initial begin
    repeat (60000) @(posedge i_clock);
    num_errors++;
    end_of_test();
  end

  initial begin
    {sup_ok, sup_on, reg_ok, wake_n, i_rst} = 5'h1f;
    {ext_dom, ign, strap} = 3'h0;
    num_errors = 0;
    checks_done = 0;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    t_powerup();
    t_transmit();
    t_timeout();
    t_faults();
    t_silent();
    t_sleep();
    end_of_test();
  end
endmodule : ltc_mode_ctrl_bench
